// [emp_assertions.sv]
// Timing checks on the emergency producer's object port and frame port.
// Assumes it is bound to emp_producer and sees only its ports.
module emp_assertions #(
  parameter NUM_EV = 11
) (
  input wire CLK,
  input wire RST_N,
  input wire [6:0] NODE_ID,
  input wire [NUM_EV-1:0] ERR_EVT,
  input wire OD_RD,
  input wire OD_WR,
  input wire [15:0] OD_INDEX,
  input wire [7:0] OD_SUB,
  input wire [31:0] OD_WDATA,
  input wire [31:0] OD_RDATA,
  input wire OD_ACK,
  input wire OD_ERR,
  input wire TX_REQ,
  input wire [28:0] TX_ID,
  input wire TX_EXT,
  input wire [3:0] TX_DLC,
  input wire [63:0] TX_DATA,
  input wire TX_ACK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  ack_follows_a: assert property ((OD_RD || OD_WR) |=> OD_ACK)
    else $error("strobe without answer");
  ack_cause_a: assert property (
    OD_ACK |-> $past(OD_RD) || $past(OD_WR))
    else $error("answer without strobe");
  err_with_ack_a: assert property (OD_ERR |-> OD_ACK)
    else $error("error flag alone");
  ro_write_a: assert property (
    OD_WR && OD_INDEX == 16'h1001 |=> OD_ERR)
    else $error("read-only write taken");
  frame_size_a: assert property (TX_REQ |-> TX_DLC == 4'h8
    && TX_DATA[63:32] == 32'h0) else $error("frame length wrong");
  frame_hold_a: assert property (TX_REQ && !TX_ACK |=> TX_REQ
    && $stable(TX_DATA) && $stable(TX_ID)) else $error("frame changed");
  flags_mask_a: assert property (
    TX_REQ |-> !(TX_DATA[23:16] & 8'h6E))
    else $error("unused flag bit set");
  base_id_a: assert property (
    TX_REQ && !TX_EXT |-> TX_ID[28:11] == 18'h0)
    else $error("base identifier too wide");
  len_code_a: assert property (TX_REQ && TX_DATA[31:24] == 8'h09
    |-> TX_DATA[23:0] == 24'h118210) else $error("length fault code");
  reset_idle_a: assert property ($rose(RST_N) |-> !TX_REQ && !OD_ACK)
    else $error("busy right after reset");
endmodule

bind emp_producer emp_assertions #(.NUM_EV(NUM_EV)) emp_assertions_inst (
  .CLK(CLK), .RST_N(RST_N), .NODE_ID(NODE_ID), .ERR_EVT(ERR_EVT),
  .OD_RD(OD_RD), .OD_WR(OD_WR), .OD_INDEX(OD_INDEX), .OD_SUB(OD_SUB),
  .OD_WDATA(OD_WDATA), .OD_RDATA(OD_RDATA), .OD_ACK(OD_ACK),
  .OD_ERR(OD_ERR), .TX_REQ(TX_REQ), .TX_ID(TX_ID), .TX_EXT(TX_EXT),
  .TX_DLC(TX_DLC), .TX_DATA(TX_DATA), .TX_ACK(TX_ACK));

// [emp_can_model.sv]
// Behavioural CAN controller that takes emergency frames off the producer.
// Assumes the producer holds TX_REQ until it sees one TX_ACK pulse.
module emp_can_model (
  input wire clk,
  input wire rst_n,
  input wire tx_req,
  input wire [3:0] delay,
  output reg tx_ack
);
  reg [3:0] wait_r;
  // Variable delay gives both prompt and slow bus arbitration
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_r <= 4'h0;
      tx_ack <= 1'h0;
    end
    else if (tx_ack)
    begin
      tx_ack <= 1'h0;
      wait_r <= 4'h0;
    end
    else if (tx_req)
    begin
      if (wait_r >= delay)
        tx_ack <= 1'h1;
      else
        wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// [emp_history.v]
// Error history store: newest entry at position 0, oldest dropped.
// Assumes push and clear are single-cycle strobes on the same clock.
`include "emp_map.vh"

module emp_history #(
  parameter DEPTH = `EMP_HIST_DEPTH,
  parameter W = 24
) (
  input wire clk,
  input wire rst_n,
  input wire push,
  input wire clear,
  input wire [W-1:0] entry,
  input wire [2:0] sel,
  output reg [2:0] count,
  output reg [W-1:0] rd_entry
);
  reg [W-1:0] mem [0:DEPTH-1];
  integer i;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= 3'h0;
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= {W{1'b0}};
    end
    else if (clear)
    begin
      // A push in the same cycle survives the clear
      count <= push ? 3'h1 : 3'h0;
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= {W{1'b0}};
      if (push)
        mem[0] <= entry;
    end
    else if (push)
    begin
      // Older entries slide one place toward the oldest slot
      for (i = DEPTH - 1; i > 0; i = i - 1)
        mem[i] <= mem[i-1];
      mem[0] <= entry;
      if (count != DEPTH[2:0])
        count <= count + 3'h1;
    end
  end

  always @*
  begin
    rd_entry = {W{1'b0}};
    if (sel < count)
      rd_entry = mem[sel];
  end
endmodule

// [emp_map.vh]
// Constants for the emergency message producer: object indexes,
// identifier fields, error codes and error register values.
// Assumes inclusion by bare name from the design files.
`ifndef EMP_MAP_VH
`define EMP_MAP_VH

// Object dictionary indexes
`define EMP_IDX_ERRREG 16'h1001
`define EMP_IDX_HIST 16'h1003
`define EMP_IDX_EMCYID 16'h1014

// Emergency identifier fields
`define EMP_ID_INVALID_BIT 31
`define EMP_ID_RSVD_BIT 30
`define EMP_ID_EXT_BIT 29
`define EMP_ID_EXT_HI 28
`define EMP_ID_EXT_LO 11
`define EMP_ID_BASE_HI 10
`define EMP_FUNC_EMCY 4'h1

// Frame length and history depth
`define EMP_DLC 4'h8
`define EMP_HIST_DEPTH 5

// Implemented error register bits: generic, communication, manufacturer
`define EMP_ERRREG_MASK 8'h91

// Event numbers; the first manufacturer byte equals the event number
`define EMP_NUM_EV 11
`define EMP_EV_NONE 4'h0
`define EMP_EV_CANCTL 4'h1
`define EMP_EV_NVMEM 4'h2
`define EMP_EV_SERIAL 4'h3
`define EMP_EV_RXOVR 4'h4
`define EMP_EV_TXOVR 4'h5
`define EMP_EV_CANOVR 4'h6
`define EMP_EV_GUARD 4'h7
`define EMP_EV_BUSOFF 4'h8
`define EMP_EV_PDOLEN 4'h9
`define EMP_EV_RESET 4'hA

// Emergency error codes
`define EMP_CODE_NONE 16'h0000
`define EMP_CODE_CANCTL 16'h1000
`define EMP_CODE_ACCESS 16'h5000
`define EMP_CODE_OVERRUN 16'h8110
`define EMP_CODE_GUARD 16'h8130
`define EMP_CODE_BUSOFF 16'h8140
`define EMP_CODE_PDOLEN 16'h8210
`define EMP_CODE_RESET 16'hFF00

// Error register values
`define EMP_REG_NONE 8'h00
`define EMP_REG_HW 8'h81
`define EMP_REG_COMM 8'h11
`define EMP_REG_RESET 8'h80

`endif

// [emp_producer.v]
// Emergency frame producer with its identifier, error register and
// error history objects, reached through a single-cycle object access port.
// Assumes error events, object access and transmit acknowledge come from
// logic on CLK; only the node address switch is asynchronous.
`include "emp_map.vh"

// What this block does
// - No emergency frame is produced while identifier bit 31 is set.
// - Identifier bit 29 picks base or extended format; bit 30 reads zero.
// - Bits 10..0 are low identifier; 28..11 zero unless extended.
// - Identifier lives at object 0x1014 and the master may rewrite it.
// - Default identifier is function code 0001 then 7-bit node address.
// - Each internal error event sends one emergency frame.
// - After each send the event joins a five-entry history at object 0x1003.
// - History is newest first; sub-index 1 newest, 5 oldest.
// - Frame is 8 bytes: code, error register, manufacturer field.
// - Error register keeps only bits 0, 4 and 7.
// - Error reset frame is all zero.
// - Controller fault gives code 1000, register 81, byte 01.
// - Memory and serial access faults give 5000, 81, bytes 02 and 03.
// - Buffer and controller overruns give 8110, 11, bytes 04 to 06.
// - Guarding failure 8130 byte 07; bus-off recovery 8140 byte 08; 11.
// - Process data length mismatch gives 8210, 11, byte 09.
// - Reset request gives FF00, register 80, byte 0A.
// - Sent error register byte is readable at object 0x1001.
// - History entries return error code with manufacturer byte.
module emp_producer #(
  parameter NUM_EV = `EMP_NUM_EV
) (
  input wire CLK,
  input wire RST_N,
  input wire [6:0] NODE_ID,
  input wire [NUM_EV-1:0] ERR_EVT,
  input wire OD_RD,
  input wire OD_WR,
  input wire [15:0] OD_INDEX,
  input wire [7:0] OD_SUB,
  input wire [31:0] OD_WDATA,
  output reg [31:0] OD_RDATA,
  output reg OD_ACK,
  output reg OD_ERR,
  output reg TX_REQ,
  output reg [28:0] TX_ID,
  output reg TX_EXT,
  output reg [3:0] TX_DLC,
  output reg [63:0] TX_DATA,
  input wire TX_ACK
);
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg state_r;
  reg state_nxt;
  reg [6:0] node_s1_r;
  reg [6:0] node_s2_r;
  reg [NUM_EV-1:0] pend_r;
  reg [NUM_EV-1:0] pend_nxt;
  reg [NUM_EV-1:0] take;
  reg [31:0] id_r;
  reg id_user_r;
  reg [7:0] errreg_r;
  reg [15:0] cur_code_r;
  reg [7:0] cur_mfr_r;
  reg [7:0] cur_reg_r;
  reg [3:0] sel_ev;
  reg found;
  reg [15:0] sel_code;
  reg [7:0] sel_reg;
  reg [31:0] id_view;
  reg [31:0] wr_id;
  reg [31:0] rd_val;
  reg rd_err;
  reg wr_err;
  reg hist_clear;
  wire hist_push;
  wire [2:0] hist_count;
  wire [23:0] hist_entry;
  wire enabled;
  integer k;

  // Rotary switch is asynchronous to CLK
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      node_s1_r <= 7'h00;
      node_s2_r <= 7'h00;
    end
    else
    begin
      node_s1_r <= NODE_ID;
      node_s2_r <= node_s1_r;
    end
  end

  // Default follows the switch until the master writes its own value
  always @*
  begin
    if (id_user_r)
      id_view = id_r;
    else
      id_view = {21'h000000, `EMP_FUNC_EMCY, node_s2_r};
  end

  assign enabled = ~id_view[`EMP_ID_INVALID_BIT];

  // Lowest event number wins when several are pending
  always @*
  begin
    sel_ev = 4'h0;
    found = 1'b0;
    take = {NUM_EV{1'b0}};
    for (k = NUM_EV - 1; k >= 0; k = k - 1)
    begin
      if (pend_r[k])
      begin
        sel_ev = k[3:0];
        found = 1'b1;
      end
    end
    if (found && state_r == ST_IDLE && enabled)
      take[sel_ev] = 1'b1;
  end

  // Code and register per event; manufacturer byte is the event number
  always @*
  begin
    case (sel_ev)
      `EMP_EV_NONE:
      begin
        sel_code = `EMP_CODE_NONE;
        sel_reg = `EMP_REG_NONE;
      end
      `EMP_EV_CANCTL:
      begin
        sel_code = `EMP_CODE_CANCTL;
        sel_reg = `EMP_REG_HW;
      end
      `EMP_EV_NVMEM, `EMP_EV_SERIAL:
      begin
        sel_code = `EMP_CODE_ACCESS;
        sel_reg = `EMP_REG_HW;
      end
      `EMP_EV_RXOVR, `EMP_EV_TXOVR, `EMP_EV_CANOVR:
      begin
        sel_code = `EMP_CODE_OVERRUN;
        sel_reg = `EMP_REG_COMM;
      end
      `EMP_EV_GUARD:
      begin
        sel_code = `EMP_CODE_GUARD;
        sel_reg = `EMP_REG_COMM;
      end
      `EMP_EV_BUSOFF:
      begin
        sel_code = `EMP_CODE_BUSOFF;
        sel_reg = `EMP_REG_COMM;
      end
      `EMP_EV_PDOLEN:
      begin
        sel_code = `EMP_CODE_PDOLEN;
        sel_reg = `EMP_REG_COMM;
      end
      `EMP_EV_RESET:
      begin
        sel_code = `EMP_CODE_RESET;
        sel_reg = `EMP_REG_RESET;
      end
      default:
      begin
        sel_code = `EMP_CODE_NONE;
        sel_reg = `EMP_REG_NONE;
      end
    endcase
  end

  // A new event in the cycle its pending bit is taken is kept
  always @*
  begin
    if (!enabled)
      pend_nxt = {NUM_EV{1'b0}};
    else
      pend_nxt = (pend_r & ~take) | ERR_EVT;
  end

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (|take)
          state_nxt = ST_WAIT;
      ST_WAIT:
        if (TX_ACK)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  assign hist_push = (state_r == ST_WAIT) && TX_ACK;

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_r <= ST_IDLE;
      pend_r <= {NUM_EV{1'b0}};
      errreg_r <= 8'h00;
      cur_code_r <= 16'h0000;
      cur_mfr_r <= 8'h00;
      cur_reg_r <= 8'h00;
      TX_REQ <= 1'b0;
      TX_ID <= 29'h00000000;
      TX_EXT <= 1'b0;
      TX_DLC <= 4'h0;
      TX_DATA <= 64'h0000000000000000;
    end
    else
    begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      if (|take)
      begin
        cur_code_r <= sel_code;
        cur_mfr_r <= {4'h0, sel_ev};
        cur_reg_r <= sel_reg & `EMP_ERRREG_MASK;
        TX_REQ <= 1'b1;
        TX_EXT <= id_view[`EMP_ID_EXT_BIT];
        if (id_view[`EMP_ID_EXT_BIT])
          TX_ID <= id_view[28:0];
        else
          TX_ID <= {18'h00000, id_view[`EMP_ID_BASE_HI:0]};
        TX_DLC <= `EMP_DLC;
        // Code goes out low byte first, as the consumer expects
        TX_DATA <= {32'h00000000, {4'h0, sel_ev}, sel_reg & `EMP_ERRREG_MASK,
          sel_code[15:8], sel_code[7:0]};
      end
      else if (hist_push)
      begin
        TX_REQ <= 1'b0;
        errreg_r <= cur_reg_r;
      end
    end
  end

  emp_history #(
    .DEPTH(`EMP_HIST_DEPTH),
    .W(24)
  ) u_hist (
    .clk(CLK),
    .rst_n(RST_N),
    .push(hist_push),
    .clear(hist_clear),
    .entry({cur_mfr_r, cur_code_r}),
    .sel(OD_SUB[2:0] - 3'h1),
    .count(hist_count),
    .rd_entry(hist_entry)
  );

  // Reserved bit forced low; upper bits cleared in base format
  always @*
  begin
    wr_id = OD_WDATA;
    wr_id[`EMP_ID_RSVD_BIT] = 1'b0;
    if (!OD_WDATA[`EMP_ID_EXT_BIT])
      wr_id[`EMP_ID_EXT_HI:`EMP_ID_EXT_LO] = 18'h00000;
  end

  always @*
  begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    case (OD_INDEX)
      `EMP_IDX_ERRREG:
        if (OD_SUB == 8'h00)
          rd_val = {24'h000000, errreg_r};
        else
          rd_err = 1'b1;
      `EMP_IDX_HIST:
        if (OD_SUB == 8'h00)
          rd_val = {29'h00000000, hist_count};
        else if (OD_SUB <= 8'h05)
          rd_val = {8'h00, hist_entry};
        else
          rd_err = 1'b1;
      `EMP_IDX_EMCYID:
        if (OD_SUB == 8'h00)
          rd_val = id_view;
        else
          rd_err = 1'b1;
      default:
        rd_err = 1'b1;
    endcase
  end

  // Only the identifier and a zero to the history count are writable
  always @*
  begin
    wr_err = 1'b1;
    hist_clear = 1'b0;
    if (OD_WR && OD_SUB == 8'h00)
    begin
      if (OD_INDEX == `EMP_IDX_EMCYID)
        wr_err = 1'b0;
      else if (OD_INDEX == `EMP_IDX_HIST && OD_WDATA == 32'h00000000)
      begin
        wr_err = 1'b0;
        hist_clear = 1'b1;
      end
    end
  end

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      id_r <= 32'h00000000;
      id_user_r <= 1'b0;
      OD_RDATA <= 32'h00000000;
      OD_ACK <= 1'b0;
      OD_ERR <= 1'b0;
    end
    else
    begin
      OD_ACK <= OD_RD | OD_WR;
      OD_ERR <= 1'b0;
      if (OD_WR)
      begin
        OD_ERR <= wr_err;
        OD_RDATA <= 32'h00000000;
        if (!wr_err && OD_INDEX == `EMP_IDX_EMCYID)
        begin
          id_r <= wr_id;
          id_user_r <= 1'b1;
        end
      end
      else if (OD_RD)
      begin
        OD_ERR <= rd_err;
        OD_RDATA <= rd_val;
      end
    end
  end
endmodule

// [tb_top.sv]
// Self-checking bench for the emergency producer and its objects.
// Assumes the CAN controller model acknowledges every offered frame.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'h0, RST_N = 1'h0, OD_RD = 1'h0, OD_WR = 1'h0;
  logic [6:0] NODE_ID = 7'h05;
  logic [10:0] ERR_EVT = 11'h000;
  logic [15:0] OD_INDEX = 16'h0000;
  logic [7:0] OD_SUB = 8'h00;
  logic [31:0] OD_WDATA = 32'h0, OD_RDATA;
  logic OD_ACK, OD_ERR, TX_REQ, TX_EXT, TX_ACK;
  logic [28:0] TX_ID;
  logic [3:0] TX_DLC, dly = 4'h0;
  logic [63:0] TX_DATA;
  int fail_count = 0;
  int check_count = 0;
  logic [15:0] code_t [11] = '{16'h0000, 16'h1000, 16'h5000, 16'h5000,
    16'h8110, 16'h8110, 16'h8110, 16'h8130, 16'h8140, 16'h8210, 16'hFF00};
  logic [7:0] reg_t [11] = '{8'h00, 8'h81, 8'h81, 8'h81, 8'h11, 8'h11,
    8'h11, 8'h11, 8'h11, 8'h11, 8'h80};
  always #12.5 CLK = ~CLK;
  emp_producer emp_producer_inst (.CLK(CLK), .RST_N(RST_N),
    .NODE_ID(NODE_ID), .ERR_EVT(ERR_EVT), .OD_RD(OD_RD), .OD_WR(OD_WR),
    .OD_INDEX(OD_INDEX), .OD_SUB(OD_SUB), .OD_WDATA(OD_WDATA),
    .OD_RDATA(OD_RDATA), .OD_ACK(OD_ACK), .OD_ERR(OD_ERR),
    .TX_REQ(TX_REQ), .TX_ID(TX_ID), .TX_EXT(TX_EXT), .TX_DLC(TX_DLC),
    .TX_DATA(TX_DATA), .TX_ACK(TX_ACK));
  emp_can_model emp_can_model_inst (.clk(CLK), .rst_n(RST_N),
    .tx_req(TX_REQ), .delay(dly), .tx_ack(TX_ACK));
  task stop_test;
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  // One object access; answer is due exactly one cycle later
  task od(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
    input logic [31:0] wd, input logic [31:0] exp, input logic err);
    @(posedge CLK);
    #1;
    OD_WR = wr;
    OD_RD = !wr;
    OD_INDEX = idx;
    OD_SUB = sub;
    OD_WDATA = wd;
    @(posedge CLK);
    #1;
    OD_WR = 1'h0;
    OD_RD = 1'h0;
    chk(OD_ACK, 1'h1);
    chk(OD_ERR, err);
    if (!err)
      chk(OD_RDATA, exp);
  endtask
  // Raise one event; on=0 means production is switched off
  task fire(input logic [3:0] n, input logic [28:0] id, input logic ext,
    input logic on);
    int k;
    k = 0;
    @(posedge CLK);
    #1;
    ERR_EVT[n] = 1'h1;
    @(posedge CLK);
    #1;
    ERR_EVT = 11'h000;
    if (!on)
    begin
      repeat (8) @(posedge CLK);
      #1;
      chk(TX_REQ, 1'h0);
    end
    else
    begin
      @(posedge CLK);
      #1;
      chk(TX_REQ, 1'h1);
      chk({TX_EXT, TX_ID}, {ext, id});
      chk(TX_DLC, 4'h8);
      chk(TX_DATA, {32'h0, 4'h0, n, reg_t[n], code_t[n]});
      while (TX_REQ === 1'h1 && k < 40)
      begin
        @(posedge CLK);
        #1;
        k++;
      end
      chk(TX_REQ, 1'h0);
      od(0, 16'h1001, 8'h00, 32'h0, {24'h0, reg_t[n]}, 0);
      od(0, 16'h1003, 8'h01, 32'h0, {12'h0, n, code_t[n]}, 0);
    end
  endtask
  initial
  begin
    #200us;
    fail_count++;
    stop_test;
  end
  initial
  begin
    repeat (3) @(posedge CLK);
    #1;
    RST_N = 1'h1;
    // Address switch needs two edges to settle
    repeat (2) @(posedge CLK);
    od(0, 16'h1001, 8'h00, 32'h0, 32'h0, 0);
    od(0, 16'h1003, 8'h00, 32'h0, 32'h0, 0);
    od(0, 16'h1014, 8'h00, 32'h0, 32'h85, 0);
    od(0, 16'h2000, 8'h00, 32'h0, 32'h0, 1);
    od(1, 16'h1001, 8'h00, 32'h1, 32'h0, 1);
    for (int i = 0; i < 11; i++)
    begin
      dly = i[3:0];
      fire(i[3:0], 29'h085, 0, 1);
    end
    od(0, 16'h1003, 8'h00, 32'h0, 32'h5, 0);
    for (int s = 1; s <= 5; s++)
      od(0, 16'h1003, s[7:0], 32'h0, {8'h00, 8'(11 - s),
        code_t[11 - s]}, 0);
    od(1, 16'h1014, 8'h00, 32'hC000_0123, 32'h0, 0);
    od(0, 16'h1014, 8'h00, 32'h0, 32'h8000_0123, 0);
    fire(4'h1, 29'h0, 0, 0);
    od(1, 16'h1014, 8'h00, 32'h7FFF_FFFF, 32'h0, 0);
    od(0, 16'h1014, 8'h00, 32'h0, 32'h3FFF_FFFF, 0);
    fire(4'h2, 29'h1FFF_FFFF, 1, 1);
    od(1, 16'h1014, 8'h00, 32'h0000_1FFF, 32'h0, 0);
    fire(4'h3, 29'h7FF, 0, 1);
    od(1, 16'h1003, 8'h00, 32'h0, 32'h0, 0);
    od(0, 16'h1003, 8'h00, 32'h0, 32'h0, 0);
    stop_test;
  end
endmodule
